// [hdl/fcp_cfg.svh]
// configuration constants for the configuration port
`ifndef FCP_CFG_SVH
`define FCP_CFG_SVH
`define FCP_MODE_REBOOT 3'h0
`define FCP_MODE_SERIAL 3'h3
`define FCP_MODE_PARALLEL 3'h6
`define FCP_PREAMBLE 8'hb2
`define FCP_POSTAMBLE 8'h4d
`define FCP_REBOOT_CYCLES 4'h8
`define FCP_IDLE_CYCLES 2'h2
`define FCP_SETTLE_PULSES 5'h18
`define FCP_CLK_DIV 3'h4
`define FCP_BIT_LAST 3'h7
`endif

// [hdl/fcp_device.sv]
// configuration port of the device, clocked by the link clock, with its system-side outputs on clock
`include "fcp_cfg.svh"
`default_nettype none
module fcp_device (
    fcp_link_if.dev link,
    input wire logic clock,
    input wire logic sys_rst,
    output logic userIoEnable,
    output logic [7:0] cfgByte,
    output logic cfgByteValid,
    output logic cfgDone
);
    // ==========================================================
    // link domain
    // no reset here: only a mode-zero reboot brings this side to a known state
    fcp_pkg::fcp_dev_state_type state_reg, state_next;
    logic [2:0] modeMeta_reg, modeSync_reg;
    logic [3:0] cnt_reg, cnt_next;
    logic [2:0] bitIdx_reg;
    logic [7:0] shift_reg;
    logic [7:0] lastByte_reg;
    logic byteTog_reg;
    logic chainOut_reg;
    logic error_reg;
    logic [7:0] stored [0:255];
    logic [7:0] addr_reg;
    logic doneLvl_reg;
    logic ioEn_reg;
    // token compare shared by the framing checks
    function automatic logic is_token(input logic [7:0] value, input logic [7:0] token);
        return value == token;
    endfunction

    wire rebootReq = modeSync_reg == `FCP_MODE_REBOOT;
    wire parallelMode = modeSync_reg == `FCP_MODE_PARALLEL;
    wire selected = !link.selectN;
    wire [7:0] serByte = {link.serialData, shift_reg[7:1]};
    // parallel bytes are taken on each link clock while write is low
    wire parStrobe = parallelMode && !link.writeN;
    wire serStrobe = !parallelMode && bitIdx_reg == `FCP_BIT_LAST;
    wire loading = state_reg == fcp_pkg::FCP_LOAD && selected && !link.configStrobeN;
    wire byteDone = loading && (parStrobe || serStrobe);
    wire [7:0] newByte = parallelMode ? link.parData : serByte;
    wire firstByte = addr_reg == 8'h00;
    wire badPre = byteDone && firstByte && !is_token(newByte, `FCP_PREAMBLE);
    wire verifyBad = byteDone && !link.verifyN && stored[addr_reg] != newByte;
    wire chainPre = byteDone && !firstByte && is_token(newByte, `FCP_PREAMBLE);
    wire postSeen = byteDone && !firstByte && is_token(newByte, `FCP_POSTAMBLE);

    // ==========================================================
    // mode sync and sequencer
    always_ff @(posedge link.configClock) begin
        modeMeta_reg <= link.modeSel;
        modeSync_reg <= modeMeta_reg;
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            fcp_pkg::FCP_REBOOT: begin
                cnt_next = cnt_reg + 4'h1;
                if (!rebootReq && cnt_reg >= `FCP_REBOOT_CYCLES) begin
                    state_next = fcp_pkg::FCP_IDLE;
                    cnt_next = 4'h0;
                end
            end
            fcp_pkg::FCP_IDLE: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == {2'h0, `FCP_IDLE_CYCLES} - 4'h1) begin
                    state_next = fcp_pkg::FCP_STANDBY;
                end
            end
            fcp_pkg::FCP_STANDBY: begin
                if (selected && !link.configStrobeN) begin
                    state_next = fcp_pkg::FCP_LOAD;
                end
            end
            fcp_pkg::FCP_LOAD: begin
                if (postSeen) begin
                    state_next = fcp_pkg::FCP_DONE;
                end else if (chainPre) begin
                    // what follows is meant for the next device in the chain
                    state_next = fcp_pkg::FCP_DONE;
                end
            end
            fcp_pkg::FCP_DONE: begin
                if (link.configStrobeN) begin
                    state_next = fcp_pkg::FCP_STANDBY;
                end
            end
            default: state_next = fcp_pkg::FCP_REBOOT;
        endcase
        if (rebootReq) begin
            state_next = fcp_pkg::FCP_REBOOT;
            cnt_next = 4'h0;
        end
    end

    always_ff @(posedge link.configClock) begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
    end

    // ==========================================================
    // data path
    // everything down to the system domain samples on the rising link clock
    always_ff @(posedge link.configClock) begin
        if (state_reg != fcp_pkg::FCP_LOAD) begin
            bitIdx_reg <= 3'h0;
            addr_reg <= 8'h00;
        end else if (loading && !parallelMode) begin
            bitIdx_reg <= bitIdx_reg + 3'h1;
            shift_reg <= serByte;
        end
        if (byteDone) begin
            lastByte_reg <= newByte;
            byteTog_reg <= !byteTog_reg;
            addr_reg <= addr_reg + 8'h01;
            if (link.verifyN) begin
                stored[addr_reg] <= newByte;
            end
        end
        if (rebootReq) begin
            byteTog_reg <= 1'b0;
        end
    end

    // ==========================================================
    // status flags
    always_ff @(posedge link.configClock) begin
        if (rebootReq) begin
            error_reg <= 1'b0;
            chainOut_reg <= 1'b0;
            doneLvl_reg <= 1'b0;
            ioEn_reg <= 1'b0;
        end else begin
            if (badPre || verifyBad) begin
                error_reg <= 1'b1;
            end
            if (chainPre) begin
                chainOut_reg <= 1'b1;
            end
            if (state_reg == fcp_pkg::FCP_DONE) begin
                doneLvl_reg <= 1'b1;
                ioEn_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // link outputs
    // strobe: driven low while rebooting, or loading while the chain output is clear, released to end the cycle
    assign link.strobeOutDev = 1'b0;
    assign link.strobeOeDev = state_reg == fcp_pkg::FCP_REBOOT
        || (state_reg == fcp_pkg::FCP_LOAD && !chainOut_reg);
    assign link.errorOeDev = error_reg;
    assign link.chainSelectOutN = !chainOut_reg;

    // ==========================================================
    // system domain: byte toggle and done level cross over
    logic [2:0] togSync_reg;
    logic [1:0] doneSync_reg;
    logic [1:0] ioSync_reg;
    always_ff @(posedge clock) begin
        togSync_reg <= {togSync_reg[1:0], byteTog_reg};
        doneSync_reg <= {doneSync_reg[0], doneLvl_reg};
        ioSync_reg <= {ioSync_reg[0], ioEn_reg};
        if (sys_rst) begin
            cfgByteValid <= 1'b0;
            cfgByte <= 8'h00;
            cfgDone <= 1'b0;
            userIoEnable <= 1'b0;
            togSync_reg <= 3'h0;
            doneSync_reg <= 2'h0;
            ioSync_reg <= 2'h0;
        end else begin
            cfgByteValid <= togSync_reg[2] != togSync_reg[1];
            // byte is stable for many fast clocks after its toggle
            if (togSync_reg[2] != togSync_reg[1]) begin
                cfgByte <= lastByte_reg;
            end
            cfgDone <= doneSync_reg[1];
            userIoEnable <= ioSync_reg[1];
        end
    end
endmodule // fcp_device
`default_nettype wire

// [hdl/fcp_host.sv]
// controller end: drives link clock, strobe and data from byte requests
`include "fcp_cfg.svh"
`default_nettype none
module fcp_host (
    fcp_link_if.host link,
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic startReq,
    input wire logic rebootReq,
    input wire logic parallelSel,
    input wire logic verifySel,
    input wire logic [7:0] txByte,
    input wire logic txValid,
    input wire logic txLast,
    output logic txReady,
    output logic busy,
    output logic failed
);
    // ==========================================================
    // divided link clock
    fcp_pkg::fcp_host_state_type state_reg;
    logic [2:0] div_reg;
    logic clkOut_reg;
    logic [4:0] pulses_reg;
    logic [2:0] bit_reg;
    logic [7:0] byte_reg;
    logic last_reg;
    logic strobeLow_reg;
    logic writeLow_reg;
    logic [1:0] errSync_reg, conSync_reg;
    wire tick = div_reg == `FCP_CLK_DIV - 3'h1;
    wire fall = tick && clkOut_reg;
    wire errLow = !errSync_reg[1];
    wire conHigh = conSync_reg[1];
    // mode zero stands long enough for the far synchroniser, whatever the request length
    wire bootHeld = pulses_reg >= {1'b0, `FCP_REBOOT_CYCLES};
    assign txReady = state_reg == fcp_pkg::FCP_H_SEND && fall && !last_reg && !errLow
        && (parallelSel || bit_reg == `FCP_BIT_LAST);
    assign busy = state_reg != fcp_pkg::FCP_H_IDLE;

    always_ff @(posedge clock) begin
        errSync_reg <= {errSync_reg[0], link.errorN};
        conSync_reg <= {conSync_reg[0], link.configStrobeN};
        div_reg <= tick ? 3'h0 : div_reg + 3'h1;
        if (tick) begin
            clkOut_reg <= !clkOut_reg;
        end
        if (sys_rst) begin
            div_reg <= 3'h0;
            clkOut_reg <= 1'b0;
            state_reg <= fcp_pkg::FCP_H_IDLE;
            pulses_reg <= 5'h00;
            bit_reg <= 3'h0;
            byte_reg <= 8'h00;
            last_reg <= 1'b0;
            strobeLow_reg <= 1'b0;
            writeLow_reg <= 1'b0;
            failed <= 1'b0;
        end else if (fall) begin
            unique case (state_reg)
                fcp_pkg::FCP_H_IDLE: begin
                    pulses_reg <= 5'h00;
                    if (rebootReq) begin
                        state_reg <= fcp_pkg::FCP_H_BOOT;
                    end else if (startReq) begin
                        failed <= 1'b0;
                        state_reg <= fcp_pkg::FCP_H_PRE;
                    end
                end
                fcp_pkg::FCP_H_BOOT: begin
                    if (!bootHeld) begin
                        pulses_reg <= pulses_reg + 5'h01;
                    end
                    if (bootHeld && !rebootReq && conHigh) begin
                        state_reg <= fcp_pkg::FCP_H_IDLE;
                    end
                end
                fcp_pkg::FCP_H_PRE: begin
                    pulses_reg <= pulses_reg + 5'h01;
                    if (pulses_reg == `FCP_SETTLE_PULSES - 5'h01) begin
                        strobeLow_reg <= 1'b1;
                        // first send slot loads a byte instead of shifting
                        bit_reg <= `FCP_BIT_LAST;
                        state_reg <= fcp_pkg::FCP_H_SEND;
                    end
                end
                fcp_pkg::FCP_H_SEND: begin
                    writeLow_reg <= 1'b0;
                    if (errLow) begin
                        failed <= 1'b1;
                        strobeLow_reg <= 1'b0;
                        state_reg <= fcp_pkg::FCP_H_IDLE;
                    end else if (parallelSel || bit_reg == `FCP_BIT_LAST) begin
                        if (last_reg) begin
                            strobeLow_reg <= 1'b0;
                            state_reg <= fcp_pkg::FCP_H_WAITEND;
                        end else if (txValid) begin
                            byte_reg <= txByte;
                            last_reg <= txLast;
                            bit_reg <= 3'h0;
                            writeLow_reg <= parallelSel;
                        end
                    end else begin
                        bit_reg <= bit_reg + 3'h1;
                        byte_reg <= {1'b0, byte_reg[7:1]};
                    end
                end
                fcp_pkg::FCP_H_WAITEND: begin
                    pulses_reg <= 5'h00;
                    last_reg <= 1'b0;
                    if (conHigh) begin
                        state_reg <= fcp_pkg::FCP_H_POST;
                    end
                end
                fcp_pkg::FCP_H_POST: begin
                    pulses_reg <= pulses_reg + 5'h01;
                    if (pulses_reg == `FCP_SETTLE_PULSES - 5'h01) begin
                        state_reg <= fcp_pkg::FCP_H_IDLE;
                    end
                end
                default: state_reg <= fcp_pkg::FCP_H_IDLE;
            endcase
        end
    end

    assign link.configClock = clkOut_reg;
    // mode zero is released before waiting for the strobe, else neither side moves
    assign link.modeSel = (state_reg == fcp_pkg::FCP_H_BOOT && (rebootReq || !bootHeld)) ?
        `FCP_MODE_REBOOT : (parallelSel ? `FCP_MODE_PARALLEL : `FCP_MODE_SERIAL);
    assign link.selectN = !(strobeLow_reg || state_reg == fcp_pkg::FCP_H_PRE);
    assign link.strobeOutHost = 1'b0;
    assign link.strobeOeHost = strobeLow_reg;
    assign link.serialData = byte_reg[0];
    assign link.parData = byte_reg;
    assign link.writeN = !writeLow_reg;
    assign link.verifyN = !(verifySel && strobeLow_reg);
endmodule // fcp_host
`default_nettype wire

// [hdl/fcp_link_if.sv]
// link between the configuring controller and the configuration port
`default_nettype none
interface fcp_link_if;
    logic configClock;
    logic [2:0] modeSel;
    logic selectN;
    logic strobeOutHost;
    logic strobeOeHost;
    logic strobeOutDev;
    logic strobeOeDev;
    logic serialData;
    logic [7:0] parData;
    logic writeN;
    logic verifyN;
    logic errorOeDev;
    logic chainSelectOutN;
    // open-drain style resolution of the shared strobe and error lines
    wire configStrobeN = !((strobeOeHost && !strobeOutHost) || (strobeOeDev && !strobeOutDev));
    wire errorN = !errorOeDev;
    modport host (output configClock, output modeSel, output selectN, output strobeOutHost,
        output strobeOeHost, output serialData, output parData, output writeN, output verifyN,
        input configStrobeN, input errorN, input chainSelectOutN);
    modport dev (input configClock, input modeSel, input selectN, output strobeOutDev,
        output strobeOeDev, input serialData, input parData, input writeN, input verifyN,
        input configStrobeN, output errorOeDev, output chainSelectOutN);
endinterface
`default_nettype wire

// [hdl/fcp_pkg.sv]
// types shared by both ends of the configuration port
`default_nettype none
package fcp_pkg;
    typedef enum logic [2:0] {
        FCP_REBOOT = 3'b000,
        FCP_IDLE = 3'b001,
        FCP_STANDBY = 3'b010,
        FCP_LOAD = 3'b011,
        FCP_DONE = 3'b100
    } fcp_dev_state_type;
    typedef enum logic [2:0] {
        FCP_H_IDLE = 3'b000,
        FCP_H_BOOT = 3'b001,
        FCP_H_PRE = 3'b010,
        FCP_H_SEND = 3'b011,
        FCP_H_WAITEND = 3'b100,
        FCP_H_POST = 3'b101
    } fcp_host_state_type;
endpackage
`default_nettype wire

// [verif/fcp_link_monitor.sv]
// concurrent checks on the link joining host and device
`include "fcp_cfg.svh"
`default_nettype none
module fcp_link_monitor (
    input wire logic sys_rst,
    input wire logic configClock,
    input wire logic [2:0] modeSel,
    input wire logic selectN,
    input wire logic configStrobeN,
    input wire logic serialData,
    input wire logic [7:0] parData,
    input wire logic writeN,
    input wire logic errorN,
    input wire logic chainSelectOutN
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // byte framing seen on the wire
    logic [2:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic first_reg;
    logic [4:0] preCnt_reg;
    logic armed_reg;
    wire inCfg = !selectN && !configStrobeN && armed_reg;
    wire serTake = inCfg && modeSel == `FCP_MODE_SERIAL && bitCnt_reg == `FCP_BIT_LAST;
    wire parTake = inCfg && modeSel == `FCP_MODE_PARALLEL && !writeN;
    wire take = serTake || parTake;
    wire [7:0] takeVal = parTake ? parData : {serialData, shift_reg[7:1]};
    always_ff @(posedge configClock) begin
        // the device ignores the edge on which it first sees the strobe low
        armed_reg <= !configStrobeN;
        bitCnt_reg <= configStrobeN ? 3'h0 : (inCfg ? bitCnt_reg + 3'h1 : bitCnt_reg);
        shift_reg <= inCfg ? {serialData, shift_reg[7:1]} : shift_reg;
        first_reg <= configStrobeN ? 1'b1 : (take ? 1'b0 : first_reg);
        // saturates so a long lead-in cannot wrap below the minimum
        preCnt_reg <= selectN ? 5'h00 : ((configStrobeN && preCnt_reg != 5'h1f) ?
            preCnt_reg + 5'h01 : preCnt_reg);
    end
    // ==========
    // properties
    default clocking cb @(posedge configClock); endclocking
    default disable iff (sys_rst);
    sequence s_reboot;
        (modeSel == `FCP_MODE_REBOOT)[*2];
    endsequence
    sequence s_first_take;
        take && first_reg;
    endsequence
    property p_reboot_strobe;
        s_reboot |-> ##[0:4] !configStrobeN;
    endproperty
    property p_reboot_clear;
        s_reboot |-> ##[0:4] (errorN && chainSelectOutN);
    endproperty
    property p_idle_two;
        (selectN && $rose(configStrobeN)) |-> (selectN && configStrobeN)[*2];
    endproperty
    property p_pre_pulses;
        (!selectN && $fell(configStrobeN)) |-> preCnt_reg >= 5'h18;
    endproperty
    property p_bad_pre;
        s_first_take ##0 (takeVal != `FCP_PREAMBLE) |-> ##[1:4] !errorN;
    endproperty
    property p_err_hold;
        (!errorN && modeSel != `FCP_MODE_REBOOT) |=> !errorN;
    endproperty
    property p_post_end;
        (take && !first_reg && errorN && takeVal == `FCP_POSTAMBLE) |-> ##[1:4] configStrobeN;
    endproperty
    property p_chain_sel;
        (take && !first_reg && takeVal == `FCP_PREAMBLE) |-> ##[1:4] !chainSelectOutN;
    endproperty
    a_reboot_strobe: assert property (p_reboot_strobe)
        else $error("strobe not pulled low in reboot");
    a_reboot_clear: assert property (p_reboot_clear)
        else $error("error or chain output active in reboot");
    a_idle_two: assert property (p_idle_two)
        else $error("select or strobe low too soon after reboot");
    a_pre_pulses: assert property (p_pre_pulses)
        else $error("too few lead-in pulses before strobe low");
    a_bad_pre: assert property (p_bad_pre)
        else $error("bad first byte not flagged");
    a_err_hold: assert property (p_err_hold)
        else $error("error line released before reboot");
    a_post_end: assert property (p_post_end)
        else $error("strobe not released after closing byte");
    a_chain_sel: assert property (p_chain_sel)
        else $error("chain select not asserted on second opening byte");
endmodule // fcp_link_monitor
`default_nettype wire

// [verif/tb_fpga_config_port.sv]
// self-checking bench: host and device joined over the configuration link
`default_nettype none
module tb_fpga_config_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, sys_rst = 1'b1, startReq = 1'b0, rebootReq = 1'b0;
    logic parallelSel = 1'b0, verifySel = 1'b0, txValid = 1'b0, txLast = 1'b0;
    logic [7:0] txByte = 8'h00;
    logic txReady, busy, failed, userIoEnable, cfgByteValid, cfgDone;
    logic [7:0] cfgByte, wireSh;
    logic [7:0] stream [$];
    logic [7:0] rxQ [$];
    logic [7:0] wireQ [$];
    logic wireArm = 1'b0;
    int error_cnt = 0, samples_checked = 0, wireCnt = 0, postCnt = 0;
    fcp_link_if link ();
    fcp_host u_fcp_host (.link(link), .clock(clock), .sys_rst(sys_rst), .startReq(startReq),
        .rebootReq(rebootReq), .parallelSel(parallelSel), .verifySel(verifySel),
        .txByte(txByte), .txValid(txValid), .txLast(txLast), .txReady(txReady),
        .busy(busy), .failed(failed));
    fcp_device u_fcp_device (.link(link), .clock(clock), .sys_rst(sys_rst),
        .userIoEnable(userIoEnable), .cfgByte(cfgByte), .cfgByteValid(cfgByteValid),
        .cfgDone(cfgDone));
    fcp_link_monitor u_fcp_link_monitor (.sys_rst(sys_rst), .configClock(link.configClock),
        .modeSel(link.modeSel), .selectN(link.selectN), .configStrobeN(link.configStrobeN),
        .serialData(link.serialData), .parData(link.parData), .writeN(link.writeN),
        .errorN(link.errorN), .chainSelectOutN(link.chainSelectOutN));
    always #50 clock = ~clock;
    always @(negedge clock) if (cfgByteValid === 1'b1) rxQ.push_back(cfgByte);
    // ==========
    // wire watch: rebuild serial bytes and count trailing pulses
    always @(posedge link.configClock) begin
        if (link.configStrobeN === 1'b1) begin
            wireCnt = 0;
            wireArm = 1'b0;
            postCnt = postCnt + 1;
        end else begin
            postCnt = 0;
            // the edge that first sees the strobe low carries no bit
            if (wireArm && link.selectN === 1'b0 && link.modeSel === 3'h3) begin
                wireSh = {link.serialData, wireSh[7:1]};
                wireCnt = wireCnt + 1;
                if (wireCnt == 8) begin
                    wireQ.push_back(wireSh);
                    wireCnt = 0;
                end
            end
            wireArm = 1'b1;
        end
    end
    // ==========
    // compare and wait tasks
    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // sel 0 waits on the strobe wire, sel 1 on busy
    task automatic wait_for(input string what, input int sel, input logic lvl, input int lim);
        int k;
        k = 0;
        while (((sel == 0) ? link.configStrobeN : busy) !== lvl && k < lim) begin
            @(negedge clock);
            k++;
        end
        check_bit(what, lvl, (sel == 0) ? link.configStrobeN : busy);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic reboot();
        @(posedge clock);
        rebootReq <= 1'b1;
        wait_for("reboot taken", 1, 1'b1, 40);
        wait_for("strobe low in reboot", 0, 1'b0, 400);
        @(posedge clock);
        rebootReq <= 1'b0;
        wait_for("strobe after reboot", 0, 1'b1, 800);
        // a few link clocks of quiet before any new start
        repeat (40) @(negedge clock);
        check_bit("user io after reboot", 1'b0, userIoEnable);
        check_bit("error after reboot", 1'b1, link.errorN);
        check_bit("chain out after reboot", 1'b1, link.chainSelectOutN);
        $display("test reboot done");
    endtask
    task automatic send(input string name, input logic par, ver, expErr, full);
        int k;
        rxQ.delete();
        wireQ.delete();
        @(posedge clock);
        parallelSel <= par;
        verifySel <= ver;
        startReq <= 1'b1;
        wait_for("start taken", 1, 1'b1, 40);
        @(posedge clock);
        startReq <= 1'b0;
        for (int i = 0; i < stream.size(); i++) begin
            txByte <= stream[i];
            txValid <= 1'b1;
            txLast <= (i == stream.size() - 1);
            k = 0;
            do begin
                @(negedge clock);
                k++;
            end while (txReady !== 1'b1 && failed !== 1'b1 && k < 2000);
            @(posedge clock);
            if (failed === 1'b1) break;
        end
        txValid <= 1'b0;
        txLast <= 1'b0;
        wait_for("busy ends", 1, 1'b0, 4000);
        check_bit("error line", ~expErr, link.errorN);
        check_bit("failed flag", expErr, failed);
        if (full) begin
            check_bit("strobe at end", 1'b1, link.configStrobeN);
            check_bit("config done", 1'b1, cfgDone);
            check_bit("user io on", 1'b1, userIoEnable);
            check_bit("trailing pulses", 1'b1, postCnt >= 24);
            check_bit("byte count", 1'b1, rxQ.size() == stream.size());
            foreach (rxQ[i]) check_byte("device byte", stream[i], rxQ[i]);
            if (!par) begin
                check_bit("wire count", 1'b1, wireQ.size() == stream.size());
                foreach (wireQ[i]) check_byte("wire byte", stream[i], wireQ[i]);
            end
        end
        $display("test %s done", name);
    endtask
    // ==========
    // test sequence and watchdog
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        reboot();
        stream = '{8'hb2, 8'h11, 8'ha5, 8'h3c, 8'h4d};
        send("serial", 1'b0, 1'b0, 1'b0, 1'b1);
        send("parallel", 1'b1, 1'b0, 1'b0, 1'b1);
        send("verify match", 1'b0, 1'b1, 1'b0, 1'b0);
        stream[2] = 8'h5a;
        send("verify mismatch", 1'b0, 1'b1, 1'b1, 1'b0);
        reboot();
        stream = '{8'ha3, 8'h11, 8'h4d};
        send("bad opening", 1'b0, 1'b0, 1'b1, 1'b0);
        reboot();
        stream = '{8'hb2, 8'h11, 8'h22, 8'hb2, 8'h77, 8'h4d};
        send("chained", 1'b0, 1'b0, 1'b0, 1'b0);
        check_bit("chain select out", 1'b0, link.chainSelectOutN);
        reboot();
        close_out();
    end
    initial begin
        #4000000;
        error_cnt++;
        $display("[FAIL] watchdog expected finish seen timeout");
        close_out();
    end
endmodule // tb_fpga_config_port
`default_nettype wire
